// File: verilog/history_pkg.sv
package history_pkg;
  // register offsets
  localparam logic [7:0] RUN_STOP_ADDR  = 8'h19;
  localparam logic [7:0] KEY_ADDR       = 8'h39;
  localparam logic [7:0] OVERRIDE_ADDR  = 8'h3A;
  localparam logic [7:0] WIDTH_ADDR     = 8'h3F;
  localparam logic [7:0] DELAY_ADDR     = 8'h40;
  localparam logic [7:0] VOLT_PORT_ADDR = 8'h46;
  localparam logic [7:0] CURR_PORT_ADDR = 8'h47;
  // reset values
  localparam logic [3:0] RUN_STOP_RST   = 4'hF;
  localparam logic [7:0] KEY_RST        = 8'h00;
  localparam logic       OVERRIDE_RST   = 1'b0;
  localparam logic [3:0] WIDTH_RST      = 4'hF;
  localparam logic [5:0] DELAY_RST      = 6'h19;
  // key that unlocks the override bit
  localparam logic [7:0] OVERRIDE_KEY   = 8'hA5;
  // field positions
  localparam int         VOLT_BIT       = 0;
  localparam int         CURR_BIT       = 1;
  localparam int         OVERRIDE_POS   = 0;
  // buffer geometry
  localparam int         SAMPLE_W       = 10;
  localparam logic [5:0] HIST_DEPTH     = 6'd50;
  localparam logic [5:0] DELAY_MAX      = 6'd50;
  localparam int         FIFO_DEPTH     = 8;
endpackage

// File: verilog/waveform_history_capture.sv
`timescale 1ns/1ps
// Summary of operation
// - two 10-bit 50-deep overwriting histories
// - fault shutdown stops recording after delay
// - reading a history port freezes it
// - channel switched off stops recording
// - voltage port 0x46, current port 0x47
// - run bits at 0x19, reset 0x0F
// - resolution bits at 0x3F per signal
// - 10-bit: high byte then low byte
// - 8-bit mode: one high byte each
// - stop delay 0x40 bits 5:0, max 50
// - stop delay resets to 25
// - fault latches channel off
// - enable toggle clears the latch
// - override bit forces channel on
// - no fault shutdown while forced on
// - override set needs key 0xA5 at 0x39
// - history readable any time

// ------------------------------------------------------------
// sample fifo
// ------------------------------------------------------------
module sample_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 8
) (
  input  wire logic             ref_clk_in,
  input  wire logic             nrst_in,
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  output logic                  out_valid_out,
  output logic      [WIDTH-1:0] out_data_out,
  input  wire logic             out_ready_in
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic [AW:0]      cnt_d;
  wire              push = in_valid_in & in_ready_out;
  wire              pop  = out_valid_out & out_ready_in;

  assign out_valid_out = (cnt_q != '0);
  assign out_data_out  = mem[rd_q];
  assign cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  always_ff @(posedge ref_clk_in) begin
    if (push) begin
      mem[wr_q] <= in_data_in;
    end
  end

  // ready is registered so the source sees a clean level
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wr_q         <= '0;
      rd_q         <= '0;
      cnt_q        <= '0;
      in_ready_out <= 1'b1;
    end else begin
      wr_q         <= push ? wr_q + 1'b1 : wr_q;
      rd_q         <= pop ? rd_q + 1'b1 : rd_q;
      cnt_q        <= cnt_d;
      in_ready_out <= (cnt_d != (AW+1)'(DEPTH));
    end
  end
endmodule

// ------------------------------------------------------------
// capture top
// ------------------------------------------------------------
module waveform_history_capture (
  input  wire logic       ref_clk_in,
  input  wire logic       nrst_in,
  input  wire logic       sample_valid_in,
  input  wire logic [9:0] sample_volt_in,
  input  wire logic [9:0] sample_curr_in,
  output logic            sample_ready_out,
  input  wire logic       enable_pin_in,
  input  wire logic       channel_enable_bit_a_in,
  input  wire logic       channel_enable_bit_b_in,
  input  wire logic       fault_shutdown_in,
  input  wire logic [7:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  output logic      [7:0] reg_rdata_out,
  output logic            reg_rvalid_out,
  output logic            channel_on_out,
  output logic            latched_off_out,
  output logic            override_bit_out
);
  import history_pkg::*;

  // ----------------------------------------------------------
  // pin sync and enable decode
  // ----------------------------------------------------------
  logic pin_s1_q;
  logic pin_s2_q;
  logic req_q;
  logic latch_q;
  logic fstop_q;
  logic [5:0] dly_cnt_q;

  // channel asked on only when pin and both bits agree
  wire req_on = pin_s2_q & channel_enable_bit_a_in
              & channel_enable_bit_b_in;
  wire req_fall = req_q & ~req_on;
  // forced on masks every fault
  wire trip = fault_shutdown_in & ~override_bit_out
            & req_on & ~latch_q;
  wire chan_on = override_bit_out
               | (req_on & ~latch_q);

  // ----------------------------------------------------------
  // register decode
  // ----------------------------------------------------------
  logic [3:0] run_q;
  logic [7:0] key_q;
  logic [3:0] res_q;
  logic [5:0] dly_q;
  logic [1:0] rd_frz_q;
  logic [1:0] last_port_q;

  wire wr_run   = reg_wr_in & (reg_addr_in == RUN_STOP_ADDR);
  wire wr_key   = reg_wr_in & (reg_addr_in == KEY_ADDR);
  wire wr_ovr   = reg_wr_in & (reg_addr_in == OVERRIDE_ADDR);
  wire wr_res   = reg_wr_in & (reg_addr_in == WIDTH_ADDR);
  wire wr_dly   = reg_wr_in & (reg_addr_in == DELAY_ADDR);
  wire [1:0] rd_port;
  assign rd_port[VOLT_BIT] = reg_rd_in
                           & (reg_addr_in == VOLT_PORT_ADDR);
  assign rd_port[CURR_BIT] = reg_rd_in
                           & (reg_addr_in == CURR_PORT_ADDR);
  // a first read of a port starts a new block at the oldest
  wire [1:0] blk_start = rd_port & ~last_port_q;
  // setting the bit is honoured only with the key in place
  wire ovr_set = wr_ovr & reg_wdata_in[OVERRIDE_POS]
               & (key_q == OVERRIDE_KEY);
  wire ovr_clr = wr_ovr & ~reg_wdata_in[OVERRIDE_POS];

  // ----------------------------------------------------------
  // sample fifo and record gating
  // ----------------------------------------------------------
  wire        f_valid;
  wire [19:0] f_data;
  wire        f_ready;
  // drain stalls during a block read so memory holds still
  assign f_ready = (last_port_q == 2'b00);
  wire        pop = f_valid & f_ready;
  wire [1:0]  rec;
  wire [7:0]  hbyte [2];

  sample_fifo #(
    .WIDTH (2*SAMPLE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_in    (ref_clk_in),
    .nrst_in       (nrst_in),
    .in_valid_in   (sample_valid_in),
    .in_data_in    ({sample_volt_in, sample_curr_in}),
    .in_ready_out  (sample_ready_out),
    .out_valid_out (f_valid),
    .out_data_out  (f_data),
    .out_ready_in  (f_ready)
  );

  // recording runs on through a latched-off delay window
  wire live = (chan_on | latch_q) & ~fstop_q;
  assign rec = run_q[1:0] & ~rd_frz_q & {2{live}};

  // ----------------------------------------------------------
  // per-signal history buffers
  // ----------------------------------------------------------
  for (genvar g = 0; g < 2; g++) begin : g_buf
    logic [SAMPLE_W-1:0] hist [HIST_DEPTH];
    logic [5:0]          wptr_q;
    logic                full_q;
    logic [5:0]          ridx_q;
    logic                phase_q;
    wire  [9:0]          din = (g == VOLT_BIT) ? f_data[19:10]
                                               : f_data[9:0];
    wire                 wr  = pop & rec[g];
    wire  [5:0]          oldest = full_q ? wptr_q : 6'd0;
    wire  [5:0]          span   = full_q ? HIST_DEPTH : wptr_q;
    wire  [5:0]          idx    = blk_start[g] ? 6'd0 : ridx_q;
    wire  [6:0]          sum    = {1'b0, oldest} + {1'b0, idx};
    wire  [5:0]          raddr  = (sum >= {1'b0, HIST_DEPTH})
                                ? 6'(sum - {1'b0, HIST_DEPTH})
                                : sum[5:0];
    wire  [9:0]          smp    = hist[raddr];
    wire                 hi_only = res_q[g];
    wire                 ph      = blk_start[g] ? 1'b0 : phase_q;
    // low byte carries bits 1:0, upper bits zero
    assign hbyte[g] = (hi_only | ~ph) ? smp[9:2]
                                      : {6'h00, smp[1:0]};
    wire  step_idx = hi_only | ph;
    wire  [5:0] nidx = (idx + 6'd1 >= span) ? 6'd0 : idx + 6'd1;

    always_ff @(posedge ref_clk_in) begin
      if (wr) begin
        hist[wptr_q] <= din;
      end
    end

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
        wptr_q  <= 6'd0;
        full_q  <= 1'b0;
        ridx_q  <= 6'd0;
        phase_q <= 1'b0;
      end else begin
        if (wr) begin
          // oldest entry is overwritten once the ring is full
          wptr_q <= (wptr_q == HIST_DEPTH - 6'd1) ? 6'd0
                                                   : wptr_q + 6'd1;
          full_q <= full_q | (wptr_q == HIST_DEPTH - 6'd1);
        end
        if (rd_port[g]) begin
          phase_q <= hi_only ? 1'b0 : ~ph;
          ridx_q  <= step_idx ? nidx : idx;
        end
      end
    end
  end

  // ----------------------------------------------------------
  // read mux
  // ----------------------------------------------------------
  wire [7:0] rmux =
      rd_port[VOLT_BIT]                   ? hbyte[VOLT_BIT] :
      rd_port[CURR_BIT]                   ? hbyte[CURR_BIT] :
      (reg_addr_in == RUN_STOP_ADDR)      ? {4'h0, run_q}   :
      (reg_addr_in == KEY_ADDR)           ? key_q           :
      (reg_addr_in == OVERRIDE_ADDR)      ? {7'h00, override_bit_out} :
      (reg_addr_in == WIDTH_ADDR)         ? {4'h0, res_q}   :
      (reg_addr_in == DELAY_ADDR)         ? {2'b00, dly_q}  :
                                            8'h00;

  // ----------------------------------------------------------
  // register storage
  // ----------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      run_q            <= RUN_STOP_RST;
      key_q            <= KEY_RST;
      override_bit_out <= OVERRIDE_RST;
      res_q            <= WIDTH_RST;
      dly_q            <= DELAY_RST;
      reg_rdata_out    <= 8'h00;
      reg_rvalid_out   <= 1'b0;
    end else begin
      run_q <= wr_run ? reg_wdata_in[3:0] : run_q;
      key_q <= wr_key ? reg_wdata_in : key_q;
      res_q <= wr_res ? reg_wdata_in[3:0] : res_q;
      dly_q <= wr_dly ? reg_wdata_in[5:0] : dly_q;
      if (ovr_set) begin
        override_bit_out <= 1'b1;
      end else if (ovr_clr) begin
        override_bit_out <= 1'b0;
      end
      reg_rdata_out  <= reg_rd_in ? rmux : reg_rdata_out;
      reg_rvalid_out <= reg_rd_in;
    end
  end

  // ----------------------------------------------------------
  // freeze-on-read tracking
  // ----------------------------------------------------------
  // a port read freezes its buffer until software rewrites run
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rd_frz_q    <= 2'b00;
      last_port_q <= 2'b00;
    end else begin
      rd_frz_q <= rd_port | (wr_run ? 2'b00 : rd_frz_q);
      if (reg_rd_in | reg_wr_in) begin
        last_port_q <= rd_port;
      end
    end
  end

  // ----------------------------------------------------------
  // latch-off and stop delay
  // ----------------------------------------------------------
  wire [5:0] dly_eff = (dly_q > DELAY_MAX) ? DELAY_MAX : dly_q;

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pin_s1_q        <= 1'b0;
      pin_s2_q        <= 1'b0;
      req_q           <= 1'b0;
      latch_q         <= 1'b0;
      fstop_q         <= 1'b0;
      dly_cnt_q       <= 6'd0;
      channel_on_out  <= 1'b0;
      latched_off_out <= 1'b0;
    end else begin
      pin_s1_q <= enable_pin_in;
      pin_s2_q <= pin_s1_q;
      req_q    <= req_on;
      if (req_fall) begin
        latch_q <= 1'b0;
        fstop_q <= 1'b0;
      end else if (trip) begin
        latch_q   <= 1'b1;
        dly_cnt_q <= dly_eff;
        fstop_q   <= (dly_eff == 6'd0);
      end else if (latch_q & ~fstop_q & pop) begin
        // count only samples taken after the shutdown
        dly_cnt_q <= dly_cnt_q - 6'd1;
        fstop_q   <= (dly_cnt_q == 6'd1);
      end
      channel_on_out  <= chan_on;
      latched_off_out <= latch_q;
    end
  end
endmodule

// File: test/waveform_history_capture_monitor.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// port checker
// ------------------------------------------------------------
module history_monitor
  import history_pkg::*;
(
  input wire logic       ref_clk_in,
  input wire logic       nrst_in,
  input wire logic       sample_valid_in,
  input wire logic [9:0] sample_volt_in,
  input wire logic [9:0] sample_curr_in,
  input wire logic       sample_ready_out,
  input wire logic       enable_pin_in,
  input wire logic       channel_enable_bit_a_in,
  input wire logic       channel_enable_bit_b_in,
  input wire logic       fault_shutdown_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic       reg_wr_in,
  input wire logic       reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic       reg_rvalid_out,
  input wire logic       channel_on_out,
  input wire logic       latched_off_out,
  input wire logic       override_bit_out
);
  logic [7:0] key_q;
  wire logic ovr_wr = reg_wr_in && reg_addr_in == OVERRIDE_ADDR;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);
  // shadow of the key so the lock can be judged from the ports
  always_ff @(posedge ref_clk_in or negedge nrst_in)
    if (!nrst_in)
      key_q <= KEY_RST;
    else if (reg_wr_in && reg_addr_in == KEY_ADDR)
      key_q <= reg_wdata_in;
  AST_RVALID: assert property (
    reg_rd_in |=> reg_rvalid_out) else $error("read not answered");
  AST_NO_RVALID: assert property (
    !reg_rd_in |=> !reg_rvalid_out) else $error("stray read valid");
  AST_FORCE_ON: assert property (
    override_bit_out |=> channel_on_out) else $error("forced channel off");
  AST_NO_TRIP: assert property (
    override_bit_out && !latched_off_out |=> !latched_off_out)
    else $error("latch set while forced on");
  AST_LATCH_OFF: assert property (
    latched_off_out && !override_bit_out |=> !channel_on_out)
    else $error("latched channel turned on");
  AST_KEY_LOCK: assert property (
    ovr_wr && key_q != OVERRIDE_KEY && !override_bit_out
    |=> !override_bit_out) else $error("override set without key");
  AST_KEY_OPEN: assert property (
    ovr_wr && reg_wdata_in[0] && key_q == OVERRIDE_KEY
    |=> override_bit_out) else $error("override not set with key");
  AST_OVR_CLEAR: assert property (
    ovr_wr && !reg_wdata_in[0] |=> !override_bit_out)
    else $error("override not cleared");
  AST_OVR_READ: assert property (
    reg_rd_in && reg_addr_in == OVERRIDE_ADDR
    |=> reg_rdata_out == {7'h00, $past(override_bit_out)})
    else $error("override readback wrong");
  AST_DLY_TOP: assert property (
    reg_rd_in && reg_addr_in == DELAY_ADDR |=> reg_rdata_out[7:6] == 2'h0)
    else $error("delay top bits not zero");
  cover property (override_bit_out && fault_shutdown_in);
  cover property ($rose(latched_off_out));
  cover property (reg_rd_in && reg_addr_in == CURR_PORT_ADDR);
endmodule

bind waveform_history_capture history_monitor u_mon (.*);

// File: test/history_host_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// host side of the register bus
// ------------------------------------------------------------
module history_host_model (
  input  wire logic       ref_clk_in,
  input  wire logic [7:0] reg_rdata_in,
  input  wire logic       reg_rvalid_in,
  output logic      [7:0] reg_addr_out,
  output logic      [7:0] reg_wdata_out,
  output logic            reg_wr_out,
  output logic            reg_rd_out
);
  initial begin
    reg_addr_out = 8'h00;
    reg_wdata_out = 8'h00;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    #1;
    reg_addr_out = a;
    reg_wdata_out = d;
    reg_wr_out = 1'b1;
    @(posedge ref_clk_in);
    #1;
    reg_wr_out = 1'b0;
    // released data garbled so stale values cannot pass
    reg_wdata_out = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk_in);
    #1;
    reg_addr_out = a;
    reg_rd_out = 1'b1;
    @(posedge ref_clk_in);
    #1;
    reg_rd_out = 1'b0;
    d = reg_rvalid_in ? reg_rdata_in : 8'hXX;
  endtask
endmodule

// File: test/tb_waveform_history_capture.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// bench
// ------------------------------------------------------------
module tb_waveform_history_capture;
  import history_pkg::*;
  logic       ref_clk_in = 1'b0;
  logic       nrst_in, sample_valid_in, sample_ready_out;
  logic [9:0] sample_volt_in, sample_curr_in;
  logic       pin, en_a, en_b, fault;
  logic [7:0] addr, wdata, rdata;
  logic       wr, rd, rvalid, chan_on, latched, ovr;
  logic [9:0] vq[$], cq[$], snap[$];
  int         num_errors = 0;
  int         tests_run = 0;
  waveform_history_capture DUT (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
    .sample_valid_in(sample_valid_in), .sample_volt_in(sample_volt_in),
    .sample_curr_in(sample_curr_in), .sample_ready_out(sample_ready_out),
    .enable_pin_in(pin), .channel_enable_bit_a_in(en_a),
    .channel_enable_bit_b_in(en_b), .fault_shutdown_in(fault),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
    .channel_on_out(chan_on), .latched_off_out(latched),
    .override_bit_out(ovr));
  history_host_model host (.ref_clk_in(ref_clk_in), .reg_rdata_in(rdata),
    .reg_rvalid_in(rvalid), .reg_addr_out(addr), .reg_wdata_out(wdata),
    .reg_wr_out(wr), .reg_rd_out(rd));
  always #10 ref_clk_in = ~ref_clk_in;
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask
  function automatic logic [7:0] exp_byte(logic [9:0] s, logic lo);
    return lo ? {6'h00, s[1:0]} : s[9:2];
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd(a, d);
    chk(d, e);
  endtask
  // whole block, oldest first; hi selects the one-byte form
  task automatic blk(input logic [7:0] a, input logic hi,
                     input logic [9:0] q[$]);
    logic [7:0] d;
    for (int k = 0; k < (hi ? 50 : 100); k++) begin
      host.rd(a, d);
      chk(d, exp_byte(q[hi ? k : k / 2], !hi && k % 2 == 1));
    end
  endtask
  task automatic push(input int n, input int kv, input int kc);
    logic [9:0] v;
    logic [9:0] c;
    for (int i = 0; i < n; i++) begin
      v = (i == 0) ? 10'h3FF : 10'($urandom);
      c = (i == 1) ? 10'h000 : 10'($urandom);
      sample_volt_in = v;
      sample_curr_in = c;
      sample_valid_in = 1'b1;
      while (sample_ready_out !== 1'b1)
        cyc(1);
      cyc(1);
      if (i < kv)
        vq.push_back(v);
      if (i < kc)
        cq.push_back(c);
    end
    sample_valid_in = 1'b0;
    while (vq.size() > 50)
      void'(vq.pop_front());
    while (cq.size() > 50)
      void'(cq.pop_front());
    cyc(12);
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #400000;
    num_errors++;
    $display("Error at %0t: timeout", $time);
    wrap_up();
  end
  initial begin
    void'($urandom(32'h869CB08B));
    {nrst_in, sample_valid_in, fault} = 3'h0;
    {pin, en_a, en_b} = 3'h7;
    sample_volt_in = 10'h000;
    sample_curr_in = 10'h000;
    cyc(8);
    nrst_in = 1'b1;
    chk({7'h00, sample_ready_out}, 8'h01);
    rchk(RUN_STOP_ADDR, 8'h0F);
    rchk(KEY_ADDR, 8'h00);
    rchk(OVERRIDE_ADDR, 8'h00);
    rchk(WIDTH_ADDR, 8'h0F);
    rchk(DELAY_ADDR, 8'h19);
    rchk(8'h50, 8'h00);
    host.wr(DELAY_ADDR, 8'hFF);
    rchk(DELAY_ADDR, 8'h3F);
    $display("test registers done");
    push(60, 60, 60);
    blk(VOLT_PORT_ADDR, 1'b1, vq);
    host.wr(WIDTH_ADDR, 8'h0C);
    blk(CURR_PORT_ADDR, 1'b0, cq);
    snap = vq;
    push(3, 3, 3);
    blk(VOLT_PORT_ADDR, 1'b0, snap);
    host.wr(RUN_STOP_ADDR, 8'h0F);
    cyc(12);
    blk(VOLT_PORT_ADDR, 1'b0, vq);
    host.wr(RUN_STOP_ADDR, 8'h0E);
    push(5, 0, 5);
    blk(VOLT_PORT_ADDR, 1'b0, vq);
    blk(CURR_PORT_ADDR, 1'b0, cq);
    $display("test capture done");
    host.wr(RUN_STOP_ADDR, 8'h0F);
    host.wr(DELAY_ADDR, 8'h03);
    fault = 1'b1;
    cyc(2);
    fault = 1'b0;
    cyc(2);
    chk({chan_on, latched}, 8'h01);
    push(8, 3, 3);
    blk(VOLT_PORT_ADDR, 1'b0, vq);
    en_a = 1'b0;
    cyc(2);
    en_a = 1'b1;
    cyc(3);
    chk({chan_on, latched}, 8'h02);
    $display("test fault done");
    host.wr(OVERRIDE_ADDR, 8'h01);
    rchk(OVERRIDE_ADDR, 8'h00);
    host.wr(KEY_ADDR, 8'hA5);
    host.wr(OVERRIDE_ADDR, 8'h01);
    rchk(OVERRIDE_ADDR, 8'h01);
    pin = 1'b0;
    fault = 1'b1;
    cyc(4);
    fault = 1'b0;
    chk({chan_on, latched}, 8'h02);
    host.wr(OVERRIDE_ADDR, 8'h00);
    host.wr(RUN_STOP_ADDR, 8'h0F);
    cyc(2);
    chk({7'h00, chan_on}, 8'h00);
    push(5, 0, 0);
    blk(VOLT_PORT_ADDR, 1'b0, vq);
    $display("test override done");
    wrap_up();
  end
endmodule
